// [core/acs_sequencer.sv]
// conversion sequencer: register file, conversion clock, sequence
// assumes an Avalon-MM master on clk and an analog core on clk
//
// How it works
// R1 - start runs after a full high-low pulse
// R2 - busy stays high while converting
// R3 - completion clears busy, loads result bytes
// R4 - interrupt needs global and converter enables
// R5 - conversion only while power enable is one
// R6 - power enable low switches analog off
// R7 - internal source disconnects external channel
// R8 - external source routes selected channel
// R9 - format bit arranges result across bytes
// R10 - reference select drives core reference
// R11 - amplifier reference gets input and gain
// R12 - result is twelve-bit unsigned code
// R13 - one code step is reference over 4096
// R14 - transfer offsets belong to analog core
// R15 - software sets divider first
// R16 - software configures pin function first
// R17 - polling software may keep interrupt off
// R18 - four sample ticks then twelve conversion
// R19 - completion sets request flag always
// R20 - divider gives system clock over 2^n
// R21 - start during conversion restarts sampling
// R22 - results held until next completion
`timescale 1ns/1ps
`include "acs_map.svh"

module acs_sequencer
  import acs_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clkEn,
  // avalon-mm slave
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // analog converter core
  input  wire logic [11:0] anaData,
  output acs_ana_t         anaCtrl,
  // interrupt towards the processor
  output logic             cpuIrq
);

  // register state
  logic       startBit_q;
  logic       startPrev_q;
  logic       power_q;
  logic       format_q;
  logic [3:0] extChan_q;
  logic [2:0] clkDiv_q;
  logic [2:0] source_q;
  logic [1:0] refSel_q;
  logic [2:0] ampGain_q;
  logic       ampIn_q;
  logic       gie_q;
  logic       ie_q;
  logic       req_q;
  logic [7:0] resHi_q;
  logic [7:0] resLo_q;
  logic       busy_q;

  // sequencer state
  acs_state_t state_q;
  logic [6:0] preCnt_q;
  logic [3:0] tickCnt_q;
  logic       convDone;
  logic       tick;
  logic       startRise;
  logic       startFall;

  // bus decode
  logic       acc;
  logic       wrAcc;
  logic [7:0] wrByte;
  logic [7:0] rdByte;

  // a request is taken once waitrequest has dropped
  assign acc    = (read || write) && !waitrequest;
  assign wrAcc  = acc && write;
  // registers are a byte wide; upper write data is ignored
  assign wrByte = writedata[7:0];

  // one wait state, then release for the taking edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
    end else if (clkEn) begin
      // low for one cycle only, so each request is taken once
      if ((read || write) && waitrequest) begin
        waitrequest <= 1'b0;
      end else begin
        waitrequest <= 1'b1;
      end
    end
  end

  // read mux; unmapped offsets read as zero
  always_comb begin
    rdByte = `ACS_RST_BYTE;
    unique case (address)
      `ACS_OFS_CTRL0: begin
        rdByte = {startBit_q, busy_q, power_q, format_q, extChan_q};
      end
      `ACS_OFS_CTRL1: begin
        rdByte = {1'b0, source_q, 1'b0, clkDiv_q};
      end
      `ACS_OFS_CTRL2: begin
        rdByte = {2'b00, ampIn_q, ampGain_q, refSel_q};
      end
      `ACS_OFS_RESHI: begin
        rdByte = resHi_q;
      end
      `ACS_OFS_RESLO: begin
        rdByte = resLo_q;
      end
      `ACS_OFS_INTCTL: begin
        rdByte = {5'h00, req_q, ie_q, gie_q};
      end
      default: begin
        rdByte = `ACS_RST_BYTE;
      end
    endcase
  end

  // read data loaded before the taking edge and held there
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= 32'h00000000;
    end else if (clkEn && read && waitrequest) begin
      readdata <= {24'h000000, rdByte};
    end
  end

  // control zero: start, power, format, channel
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      startBit_q <= 1'b0;
      power_q    <= 1'b0;
      format_q   <= 1'b0;
      extChan_q  <= 4'h0;
    end else if (clkEn && wrAcc && address == `ACS_OFS_CTRL0) begin
      startBit_q <= wrByte[`ACS_C0_START];
      power_q    <= wrByte[`ACS_C0_POWER]; // R5
      format_q   <= wrByte[`ACS_C0_FORMAT];
      extChan_q  <= wrByte[3:0];
    end
  end

  // control one: conversion clock divider and input source
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clkDiv_q <= 3'h0;
      source_q <= `ACS_SRC_EXT;
    end else if (clkEn && wrAcc && address == `ACS_OFS_CTRL1) begin
      clkDiv_q <= wrByte[2:0]; // R20
      source_q <= wrByte[`ACS_C1_SRC_LSB +: 3]; // R7 R8
    end
  end

  // control two: reference source and amplifier settings
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refSel_q  <= 2'h0;
      ampGain_q <= 3'h0;
      ampIn_q   <= 1'b0;
    end else if (clkEn && wrAcc && address == `ACS_OFS_CTRL2) begin
      refSel_q  <= wrByte[1:0]; // R10
      ampGain_q <= wrByte[`ACS_C2_GAIN_LSB +: 3]; // R11
      ampIn_q   <= wrByte[`ACS_C2_AMPIN]; // R11
    end
  end

  // interrupt enables
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gie_q <= 1'b0;
      ie_q  <= 1'b0;
    end else if (clkEn && wrAcc && address == `ACS_OFS_INTCTL) begin
      gie_q <= wrByte[`ACS_IC_GIE];
      ie_q  <= wrByte[`ACS_IC_IE];
    end
  end

  // request flag; completion beats a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_q <= 1'b0;
    end else if (clkEn) begin
      if (convDone) begin
        req_q <= 1'b1; // R19
      end else if (wrAcc && address == `ACS_OFS_INTCTL &&
                   !wrByte[`ACS_IC_REQ]) begin
        req_q <= 1'b0; // writing zero clears, one keeps
      end
    end
  end

  // interrupt line follows the flag through both enables
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpuIrq <= 1'b0;
    end else if (clkEn) begin
      cpuIrq <= req_q && gie_q && ie_q; // R4
    end
  end

  // start bit edges, seen only while powered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      startPrev_q <= 1'b0;
    end else if (clkEn) begin
      startPrev_q <= startBit_q;
    end
  end

  // no edge counts while unpowered, so a start is refused then
  assign startRise = power_q && startBit_q && !startPrev_q;
  assign startFall = power_q && !startBit_q && startPrev_q;

  // prescaler makes one tick per 2^div system clocks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      preCnt_q <= 7'h00;
    end else if (clkEn) begin
      // held at zero until sampling so the first tick is full length
      if (state_q == ST_IDLE || state_q == ST_ARMED || tick) begin
        preCnt_q <= 7'h00;
      end else begin
        preCnt_q <= preCnt_q + 7'h01;
      end
    end
  end

  // tick on the last count of each divided period
  assign tick = (preCnt_q == 7'((8'h01 << clkDiv_q) - 8'h01)); // R20

  // the last conversion tick completes the run
  assign convDone = (state_q == ST_CONV) && tick &&
                    (tickCnt_q == `ACS_CONV_TICKS - 4'h1);

  // conversion sequence: arm on rise, run after fall
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= ST_IDLE;
      tickCnt_q <= 4'h0;
    end else if (clkEn) begin
      // power loss and a fresh start override any phase
      if (!power_q) begin
        state_q   <= ST_IDLE; // R5
        tickCnt_q <= 4'h0;
      end else if (startRise) begin
        state_q   <= ST_ARMED; // R21
        tickCnt_q <= 4'h0;
      end else begin
        unique case (state_q)
          ST_IDLE: begin
            tickCnt_q <= 4'h0;
          end
          ST_ARMED: begin
            if (startFall) begin
              state_q <= ST_SAMPLE; // R1
            end
          end
          ST_SAMPLE: begin
            if (tick) begin
              if (tickCnt_q == `ACS_SAMPLE_TICKS - 4'h1) begin
                state_q   <= ST_CONV; // R18
                tickCnt_q <= 4'h0;
              end else begin
                tickCnt_q <= tickCnt_q + 4'h1;
              end
            end
          end
          ST_CONV: begin
            if (convDone) begin
              state_q   <= ST_IDLE; // R18
              tickCnt_q <= 4'h0;
            end else if (tick) begin
              tickCnt_q <= tickCnt_q + 4'h1;
            end
          end
        endcase
      end
    end
  end

  // busy from the start pulse's fall to completion
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
    end else if (clkEn) begin
      // clearing wins over setting when both fall together
      if (!power_q || startRise || convDone) begin
        busy_q <= 1'b0; // R3
      end else if (state_q == ST_ARMED && startFall) begin
        busy_q <= 1'b1; // R2
      end
    end
  end

  // result bytes change only on completion
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resHi_q <= `ACS_RST_BYTE;
      resLo_q <= `ACS_RST_BYTE;
    end else if (clkEn && convDone) begin // R22
      // format one right-aligns, format zero left-aligns the code
      if (format_q) begin
        resHi_q <= {4'h0, anaData[11:8]}; // R9 R12
        resLo_q <= anaData[7:0];
      end else begin
        resHi_q <= anaData[11:4]; // R9 R12
        resLo_q <= {anaData[3:0], 4'h0};
      end
    end
  end

  // analog core controls; code scaling and offsets live in the core
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      anaCtrl <= '0;
    end else if (clkEn) begin
      // registered so the core sees steady levels
      anaCtrl.power      <= power_q; // R6
      anaCtrl.sample     <= power_q && state_q == ST_SAMPLE; // R18
      anaCtrl.convert    <= power_q && state_q == ST_CONV; // R13 R14
      anaCtrl.extConnect <= power_q && source_q == `ACS_SRC_EXT; // R7 R8
      anaCtrl.channel    <= (source_q == `ACS_SRC_EXT) ? extChan_q
                                                       : 4'h0; // R7
      anaCtrl.source     <= source_q;
      anaCtrl.refSel     <= refSel_q; // R10
      anaCtrl.ampGain    <= ampGain_q; // R11
      anaCtrl.ampInput   <= ampIn_q; // R11
    end
  end

endmodule : acs_sequencer

// [include/acs_map.svh]
// register offsets, field positions, reset values and counts
// of the conversion sequencer; definitions only
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH
`define ACS_OFS_CTRL0    6'h00
`define ACS_OFS_CTRL1    6'h04
`define ACS_OFS_CTRL2    6'h08
`define ACS_OFS_RESHI    6'h0C
`define ACS_OFS_RESLO    6'h10
`define ACS_OFS_INTCTL   6'h14
`define ACS_C0_START     7
`define ACS_C0_BUSY      6
`define ACS_C0_POWER     5
`define ACS_C0_FORMAT    4
`define ACS_C1_SRC_LSB   4
`define ACS_C2_AMPIN     5
`define ACS_C2_GAIN_LSB  2
`define ACS_IC_GIE       0
`define ACS_IC_IE        1
`define ACS_IC_REQ       2
`define ACS_RST_BYTE     8'h00
`define ACS_SRC_EXT      3'h0
`define ACS_SAMPLE_TICKS 4'h4
`define ACS_CONV_TICKS   4'hC
`endif

// [include/acs_pkg.sv]
// types shared by the conversion sequencer and its bench
// assumes acs_map.svh is on the include path
package acs_pkg;
  // conversion phases, gray coded along idle-armed-sample-convert
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ARMED  = 2'b01,
    ST_SAMPLE = 2'b11,
    ST_CONV   = 2'b10
  } acs_state_t;

  // controls towards the analog converter core
  typedef struct packed {
    logic       power;
    logic       sample;
    logic       convert;
    logic       extConnect;
    logic [3:0] channel;
    logic [2:0] source;
    logic [1:0] refSel;
    logic [2:0] ampGain;
    logic       ampInput;
  } acs_ana_t;
endpackage : acs_pkg

// [verification/acs_sequencer_asserts.sv]
// port checker for the conversion sequencer
// bound to acs_sequencer below; sees only its ports
`timescale 1ns/1ps
module acs_sequencer_asserts
  import acs_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // bus
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // analog side and interrupt
  input wire acs_ana_t    anaCtrl,
  input wire logic        cpuIrq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // bus answer timing
  a_wait_answer: assert property ($rose(read || write) |=> !waitrequest)
    else $error("no answer to request");
  a_wait_single: assert property (!waitrequest |=> waitrequest)
    else $error("answer held too long");
  a_wait_cause: assert property (!waitrequest |-> $past(read || write))
    else $error("answer without request");
  a_read_upper: assert property (!waitrequest |-> readdata[31:8] == 24'h0)
    else $error("upper read bits set");
  // conversion phases
  a_power_gate: assert property (!anaCtrl.power |->
    !(anaCtrl.sample || anaCtrl.convert)) else $error("active unpowered");
  a_sample_len: assert property ($rose(anaCtrl.sample) |->
    anaCtrl.sample [*4]) else $error("sampling too short");
  a_conv_next: assert property ($fell(anaCtrl.sample) && anaCtrl.power
    |-> anaCtrl.convert) else $error("no conversion after sampling");
  a_conv_len: assert property ($rose(anaCtrl.convert) |->
    anaCtrl.convert [*8]) else $error("conversion too short");
  a_ext_off: assert property (anaCtrl.source != 3'h0 |->
    !anaCtrl.extConnect) else $error("external input left on");
  // main scenarios
  c_done: cover property ($fell(anaCtrl.convert));
  c_irq: cover property ($rose(cpuIrq));
  c_sample: cover property ($rose(anaCtrl.sample));
endmodule : acs_sequencer_asserts

bind acs_sequencer acs_sequencer_asserts acs_sequencer_asserts_inst (
  .clk(clk), .rst_n(rst_n), .read(read), .write(write),
  .readdata(readdata), .waitrequest(waitrequest), .anaCtrl(anaCtrl),
  .cpuIrq(cpuIrq));

// [verification/acs_sequencer_tb.sv]
// self-checking bench for the conversion sequencer
// assumes acs_map.svh on the include path; clock enable held high
`timescale 1ns/1ps
`include "acs_map.svh"
module acs_sequencer_tb
  import acs_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [5:0]  address = 6'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [11:0] anaData = 12'h000;
  logic [31:0] readdata;
  logic        waitrequest;
  acs_ana_t    anaCtrl;
  logic        cpuIrq;
  logic [31:0] rdv;
  int          n_fail = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          k;

  acs_sequencer acs_sequencer_inst (.clk(clk), .rst_n(rst_n),
    .clkEn(1'b1), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .anaData(anaData), .anaCtrl(anaCtrl),
    .cpuIrq(cpuIrq));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_fail = n_fail + 1;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    address <= a;
    writedata <= {24'h0, d};
    write <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    write <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [5:0] a);
    address <= a;
    read <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rdv = readdata;
    read <= 1'b0;
    @(posedge clk);
  endtask : rd

  // start bit high then low with the given control byte
  task automatic pulse(input logic [7:0] c);
    wr(`ACS_OFS_CTRL0, c | 8'h80);
    wr(`ACS_OFS_CTRL0, c);
  endtask : pulse

  task automatic wait_idle();
    rdv = 32'h40;
    for (int i = 0; i < 60 && rdv[6] !== 1'b0; i++) rd(`ACS_OFS_CTRL0);
  endtask : wait_idle

  task automatic t_reset();
    for (k = 0; k < 7; k++) begin
      rd(6'(k * 4));
      chk(rdv, 32'h0);
    end
    $display("reset values done");
  endtask : t_reset

  task automatic t_poll();
    wr(`ACS_OFS_CTRL1, 8'h00);
    wr(`ACS_OFS_CTRL0, 8'h23);
    anaData <= 12'hABC;
    @(posedge clk);
    chk(32'({anaCtrl.power, anaCtrl.extConnect, anaCtrl.channel}), 32'h33);
    wr(`ACS_OFS_CTRL0, 8'hA3);
    rd(`ACS_OFS_CTRL0);
    chk(rdv & 32'h40, 32'h0);
    wr(`ACS_OFS_CTRL0, 8'h23);
    rd(`ACS_OFS_CTRL0);
    chk(rdv & 32'h40, 32'h40);
    wait_idle();
    rd(`ACS_OFS_RESHI);
    chk(rdv, 32'hAB);
    rd(`ACS_OFS_RESLO);
    chk(rdv, 32'hC0);
    rd(`ACS_OFS_INTCTL);
    chk(rdv, 32'h04);
    chk(32'(cpuIrq), 32'h0);
    $display("polled conversion done");
  endtask : t_poll

  task automatic t_irq();
    wr(`ACS_OFS_INTCTL, 8'h03);
    wr(`ACS_OFS_CTRL1, 8'h02);
    anaData <= 12'h5E7;
    pulse(8'h33);
    for (k = 0; k < 200 && cpuIrq !== 1'b1; k++) @(posedge clk);
    chk(32'(k >= 56 && k <= 72), 32'h1);
    anaData <= 12'h111;
    rd(`ACS_OFS_RESHI);
    chk(rdv, 32'h05);
    rd(`ACS_OFS_RESLO);
    chk(rdv, 32'hE7);
    wr(`ACS_OFS_INTCTL, 8'h03);
    @(posedge clk);
    chk(32'(cpuIrq), 32'h0);
    $display("interrupt conversion done");
  endtask : t_irq

  task automatic t_select();
    wr(`ACS_OFS_CTRL1, 8'h10);
    @(posedge clk);
    chk(32'({anaCtrl.source, anaCtrl.extConnect}), 32'h2);
    wr(`ACS_OFS_CTRL2, 8'h2D);
    @(posedge clk);
    chk(32'({anaCtrl.ampInput, anaCtrl.ampGain, anaCtrl.refSel}), 32'h2D);
    wr(`ACS_OFS_CTRL0, 8'h00);
    pulse(8'h00);
    rd(`ACS_OFS_CTRL0);
    chk(rdv & 32'h40, 32'h0);
    chk(32'({anaCtrl.power, anaCtrl.sample}), 32'h0);
    $display("selection and power done");
  endtask : t_select

  task automatic t_restart();
    wr(`ACS_OFS_CTRL1, 8'h00);
    wr(`ACS_OFS_CTRL0, 8'h23);
    anaData <= 12'h9F0;
    pulse(8'h23);
    repeat (10) @(posedge clk);
    wr(`ACS_OFS_CTRL0, 8'hA3);
    rd(`ACS_OFS_CTRL0);
    chk(rdv & 32'h40, 32'h0);
    rd(`ACS_OFS_RESHI);
    chk(rdv, 32'h05);
    anaData <= 12'h0FF;
    wr(`ACS_OFS_CTRL0, 8'h23);
    wait_idle();
    rd(`ACS_OFS_RESHI);
    chk(rdv, 32'h0F);
    $display("restart done");
  endtask : t_restart

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  // reset, then the scenarios in turn
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_poll();
    t_irq();
    t_select();
    t_restart();
    final_report();
  end
endmodule : acs_sequencer_tb
